// [tcmbr_top.sv]
// Host port, connection memories, output channel engine and per-stream error receivers
`timescale 1ns/1ps
module tcmbr_top #(
	parameter int unsigned N_STREAMS = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Host port
	input wire logic host_req_i,
	input wire logic host_wr_i,
	input wire logic [tcmbr_pkg::HADDR_W-1:0] host_addr_i,
	input wire logic [tcmbr_pkg::HDATA_W-1:0] host_wdata_i,
	output logic host_ack_o,
	output logic [tcmbr_pkg::HDATA_W-1:0] host_rdata_o,
	// Received channel bytes
	input wire logic rx_valid_i,
	input wire logic [tcmbr_pkg::STR_W-1:0] rx_stream_i,
	input wire logic [tcmbr_pkg::CH_W-1:0] rx_channel_i,
	input wire logic [7:0] rx_byte_i,
	// Output channel requests and results
	input wire logic tx_req_i,
	input wire logic [tcmbr_pkg::STR_W-1:0] tx_stream_i,
	input wire logic [tcmbr_pkg::CH_W-1:0] tx_channel_i,
	output logic tx_valid_o,
	output logic [7:0] tx_byte_o,
	output logic tx_oe_o,
	output logic tx_ber_o,
	output logic tx_var_delay_o
);
	import tcmbr_pkg::*;

	function automatic logic [15:0] alaw_dec(input logic [7:0] a);
		logic [7:0] x;
		logic [15:0] t;
		x = a ^ 8'h55;
		t = {8'h00, x[3:0], 4'h0};
		if (x[6:4] == 3'h0)
			t = t + 16'h0008;
		else
			t = (t + 16'h0108) << (x[6:4] - 3'h1);
		return x[7] ? t : 16'h0000 - t;
	endfunction

	function automatic logic [15:0] mulaw_dec(input logic [7:0] u);
		logic [7:0] x;
		logic [15:0] t;
		x = ~u;
		t = ({9'h000, x[3:0], 3'h0} + 16'h0084) << x[6:4];
		return x[7] ? 16'h0084 - t : t - 16'h0084;
	endfunction

	function automatic logic [7:0] mulaw_enc(input logic [15:0] lin);
		logic [15:0] m;
		logic [2:0] seg;
		logic [15:0] sh;
		m = lin[15] ? 16'h0000 - lin : lin;
		if (m > 16'h7F7B)
			m = 16'h7F7B;
		m = m + 16'h0084;
		seg = 3'h0;
		for (int i = 1; i < 8; i++)
			if (m >= (16'h0100 << i))
				seg = 3'(i);
		// Widened so segments 5 to 7 do not wrap the shift count
		sh = m >> (4'(seg) + 4'h3);
		return {~lin[15], ~seg, ~sh[3:0]};
	endfunction

	function automatic logic [7:0] alaw_enc(input logic [15:0] lin);
		logic [15:0] p;
		logic [7:0] mask;
		logic [3:0] seg;
		logic [15:0] sh;
		p = {{3{lin[15]}}, lin[15:3]};
		mask = lin[15] ? 8'h55 : 8'hD5;
		if (lin[15])
			p = 16'hFFFF - p;
		seg = 4'h8;
		for (int i = 7; i >= 0; i--)
			if (p < (16'h0020 << i))
				seg = 4'(i);
		sh = (seg < 4'h2) ? p >> 1 : p >> seg;
		if (seg == 4'h8)
			return 8'h7F ^ mask;
		return {1'b0, seg[2:0], sh[3:0]} ^ mask;
	endfunction

	function automatic logic [7:0] translate(input logic [7:0] b, input logic [4:0] h);
		logic [1:0] input_coding_law;
		logic [1:0] output_coding_law;
		logic [15:0] lin;
		input_coding_law = h[CMH_ICL_LSB +: 2]; // see R22
		output_coding_law = h[CMH_OCL_LSB +: 2];
		if (input_coding_law == output_coding_law) // see R17
			return b;
		if (h[CMH_VD_BIT]) // see R18
			return b ^ DATA_MASKS[8*input_coding_law +: 8] ^ DATA_MASKS[8*output_coding_law +: 8];
		lin = input_coding_law[0] ? mulaw_dec(b) : alaw_dec(b); // see R16
		return output_coding_law[0] ? mulaw_enc(lin) : alaw_enc(lin);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Host port and control register

	tcmbr_host_state_t state_ff, nxt_state;
	logic [HADDR_W-1:0] haddr_ff, nxt_haddr;
	logic [HDATA_W-1:0] hwdata_ff, nxt_hwdata;
	logic hwr_ff, nxt_hwr;
	logic ack_ff, nxt_ack;
	logic [HDATA_W-1:0] rdata_ff, nxt_rdata;
	logic [2:0] ctrl_ff, nxt_ctrl;
	logic [HDATA_W-1:0] reg_rd;
	logic cml_wr, cmh_wr, cm_host_rd, dm_host_rd;
	logic [15:0] cml_q, cmh_q;
	logic [7:0] dm_q;
	logic tx_s1_ff, tx_s2_ff;
	logic [7:0] start_ff [N_STREAMS];
	logic [8:0] len_ff [N_STREAMS];
	logic [15:0] err_ff [N_STREAMS];
	logic [1:0] memsel;

	assign memsel = ctrl_ff[CTRL_MEMSEL_LSB +: 2];

	always_comb
	begin
		reg_rd = 16'h0000;
		if (host_addr_i == REG_CTRL_OFS)
			reg_rd = {13'h0000, ctrl_ff};
		for (int n = 0; n < N_STREAMS; n++)
		begin
			if (host_addr_i == REG_START_OFS + 14'(n))
				reg_rd = {8'h00, start_ff[n]};
			if (host_addr_i == REG_LEN_OFS + 14'(n))
				reg_rd = {7'h00, len_ff[n]};
			if (host_addr_i == REG_ERR_OFS + 14'(n))
				reg_rd = err_ff[n];
		end
	end

	always_comb
	begin
		nxt_state = state_ff;
		nxt_haddr = haddr_ff;
		nxt_hwdata = hwdata_ff;
		nxt_hwr = hwr_ff;
		nxt_ack = 1'b0;
		nxt_rdata = rdata_ff;
		nxt_ctrl = ctrl_ff;
		cml_wr = 1'b0;
		cmh_wr = 1'b0;
		cm_host_rd = 1'b0;
		dm_host_rd = 1'b0;
		unique case (state_ff)
			H_IDLE:
			begin
				if (host_req_i && !host_addr_i[SPACE_BIT]) // see R6
				begin
					nxt_ack = 1'b1;
					nxt_rdata = reg_rd;
					if (host_wr_i && host_addr_i == REG_CTRL_OFS)
						nxt_ctrl = host_wdata_i[2:0];
				end
				else if (host_req_i)
				begin
					nxt_haddr = host_addr_i;
					nxt_hwdata = host_wdata_i;
					nxt_hwr = host_wr_i;
					nxt_state = H_MEM;
				end
			end
			H_MEM:
			begin
				// Output engine owns the read ports; host reads wait for a free cycle
				if (hwr_ff || (memsel != MEMSEL_CM_LOW && memsel != MEMSEL_CM_HIGH && memsel != MEMSEL_DATA))
				begin
					cml_wr = hwr_ff && memsel == MEMSEL_CM_LOW; // see R7
					cmh_wr = hwr_ff && memsel == MEMSEL_CM_HIGH;
					nxt_rdata = 16'h0000;
					nxt_ack = 1'b1;
					nxt_state = H_IDLE;
				end
				else if (memsel == MEMSEL_DATA ? !tx_s1_ff : !tx_req_i)
				begin
					cm_host_rd = memsel != MEMSEL_DATA;
					dm_host_rd = memsel == MEMSEL_DATA;
					nxt_state = H_DATA;
				end
			end
			H_DATA:
			begin
				unique case (memsel)
					MEMSEL_CM_LOW: nxt_rdata = cml_q;
					MEMSEL_CM_HIGH: nxt_rdata = cmh_q;
					default: nxt_rdata = {8'h00, dm_q};
				endcase
				nxt_ack = 1'b1;
				nxt_state = H_IDLE;
			end
			default: nxt_state = H_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_ff <= H_IDLE;
			haddr_ff <= 14'h0000;
			hwdata_ff <= 16'h0000;
			hwr_ff <= 1'b0;
			ack_ff <= 1'b0;
			rdata_ff <= 16'h0000;
			ctrl_ff <= CTRL_RST;
		end
		else
		begin
			state_ff <= nxt_state;
			haddr_ff <= nxt_haddr;
			hwdata_ff <= nxt_hwdata;
			hwr_ff <= nxt_hwr;
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
			ctrl_ff <= nxt_ctrl;
		end
	end

	assign host_ack_o = ack_ff;
	assign host_rdata_o = rdata_ff;

	////////////////////////////////////////////////////////////////////////
	// Memories

	logic [MEM_AW-1:0] cm_rd_addr, tx_addr, src_addr, dm_rd_addr;

	assign tx_addr = {tx_stream_i, tx_channel_i};
	assign cm_rd_addr = tx_req_i ? tx_addr : haddr_ff[MEM_AW-1:0]; // see R8
	assign src_addr = cml_q[CML_SRC_LSB +: MEM_AW]; // see R12
	assign dm_rd_addr = tx_s1_ff ? src_addr : haddr_ff[MEM_AW-1:0];

	tcmbr_ram #(.DW(16), .AW(MEM_AW)) u_cm_low (
		.clk_i(clk_i), .wr_en_i(cml_wr), .wr_addr_i(haddr_ff[MEM_AW-1:0]), .wr_data_i(hwdata_ff),
		.rd_en_i(tx_req_i | cm_host_rd), .rd_addr_i(cm_rd_addr), .rd_data_o(cml_q));
	tcmbr_ram #(.DW(16), .AW(MEM_AW)) u_cm_high (
		.clk_i(clk_i), .wr_en_i(cmh_wr), .wr_addr_i(haddr_ff[MEM_AW-1:0]), .wr_data_i(hwdata_ff),
		.rd_en_i(tx_req_i | cm_host_rd), .rd_addr_i(cm_rd_addr), .rd_data_o(cmh_q));
	tcmbr_ram #(.DW(8), .AW(MEM_AW)) u_data (
		.clk_i(clk_i), .wr_en_i(rx_valid_i), .wr_addr_i({rx_stream_i, rx_channel_i}), .wr_data_i(rx_byte_i),
		.rd_en_i(tx_s1_ff | dm_host_rd), .rd_addr_i(dm_rd_addr), .rd_data_o(dm_q));

	////////////////////////////////////////////////////////////////////////
	// Output channel engine: request, connection word, source byte, result

	logic [15:0] s2_cml_ff, nxt_s2_cml;
	logic [4:0] s2_cmh_ff, nxt_s2_cmh;
	logic [7:0] nxt_tx_byte;
	logic nxt_tx_oe, nxt_tx_ber, nxt_tx_var, convertible;
	logic [7:0] byte_raw;

	always_comb
	begin
		nxt_s2_cml = tx_s1_ff ? cml_q : s2_cml_ff;
		nxt_s2_cmh = tx_s1_ff ? cmh_q[4:0] : s2_cmh_ff;
		byte_raw = 8'h00;
		nxt_tx_oe = 1'b1;
		nxt_tx_ber = 1'b0;
		nxt_tx_var = 1'b0;
		convertible = 1'b0;
		if (!s2_cml_ff[CML_MODE_BIT]) // see R9
		begin
			byte_raw = dm_q;
			// Variable delay only takes effect once enabled globally
			nxt_tx_var = s2_cml_ff[CML_VAR_BIT] & ctrl_ff[CTRL_VARIABLE_DELAY_ENABLE_BIT]; // see R10
			convertible = 1'b1;
		end
		else
		begin
			unique case (s2_cml_ff[CML_OSEL_LSB +: 2]) // see R14
				OSEL_MESSAGE:
				begin
					byte_raw = s2_cml_ff[CML_MSG_LSB +: 8]; // see R13
					convertible = 1'b1;
				end
				OSEL_BER: nxt_tx_ber = 1'b1;
				default: nxt_tx_oe = 1'b0;
			endcase
		end
		nxt_tx_byte = (convertible && s2_cml_ff[CML_CONV_BIT]) ? translate(byte_raw, s2_cmh_ff) : byte_raw; // see R19
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_s1_ff <= 1'b0;
			tx_s2_ff <= 1'b0;
			s2_cml_ff <= 16'h0000;
			s2_cmh_ff <= 5'h00;
			tx_valid_o <= 1'b0;
			tx_byte_o <= 8'h00;
			tx_oe_o <= 1'b0;
			tx_ber_o <= 1'b0;
			tx_var_delay_o <= 1'b0;
		end
		else
		begin
			tx_s1_ff <= tx_req_i;
			tx_s2_ff <= tx_s1_ff;
			s2_cml_ff <= nxt_s2_cml;
			s2_cmh_ff <= nxt_s2_cmh;
			tx_valid_o <= tx_s2_ff;
			tx_byte_o <= tx_s2_ff ? nxt_tx_byte : 8'h00;
			tx_oe_o <= tx_s2_ff & nxt_tx_oe;
			tx_ber_o <= tx_s2_ff & nxt_tx_ber;
			tx_var_delay_o <= tx_s2_ff & nxt_tx_var;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-stream error receivers, self-synchronising on the received pattern

	for (genvar g = 0; g < N_STREAMS; g++)
	begin : g_ber
		logic [14:0] hist_ff, nxt_hist;
		logic [7:0] nxt_start;
		logic [8:0] nxt_len;
		logic [15:0] nxt_err;
		logic [16:0] sum;
		logic [3:0] errs;
		logic hit, start_wr;

		assign start_wr = state_ff == H_IDLE && host_req_i && host_wr_i && host_addr_i == REG_START_OFS + 14'(g);
		// Zero length disables comparison for the stream
		assign hit = rx_valid_i && rx_stream_i == 5'(g) && len_ff[g] != 9'h000 && rx_channel_i >= start_ff[g]
			&& {2'h0, rx_channel_i} < {2'h0, start_ff[g]} + {1'b0, len_ff[g]}; // see R1, R2

		always_comb
		begin
			nxt_start = start_wr ? host_wdata_i[7:0] : start_ff[g]; // see R1
			nxt_len = len_ff[g];
			if (state_ff == H_IDLE && host_req_i && host_wr_i && host_addr_i == REG_LEN_OFS + 14'(g))
				nxt_len = host_wdata_i[8:0]; // see R2
			nxt_hist = hist_ff;
			errs = 4'h0;
			if (hit)
			begin
				for (int b = 7; b >= 0; b--)
				begin
					errs = errs + {3'h0, rx_byte_i[b] ^ nxt_hist[14] ^ nxt_hist[13]}; // see R21
					nxt_hist = {nxt_hist[13:0], rx_byte_i[b]};
				end
			end
			// Restarting a test clears the count, but errors seen in that cycle still land
			sum = {1'b0, start_wr ? ERR_RST : err_ff[g]} + {13'h0000, errs};
			nxt_err = sum[16] ? ERR_MAX : sum[15:0]; // see R5
		end

		always_ff @(posedge clk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
			begin
				start_ff[g] <= START_RST;
				len_ff[g] <= LEN_RST;
				err_ff[g] <= ERR_RST;
				hist_ff <= 15'h0000;
			end
			else
			begin
				start_ff[g] <= nxt_start;
				len_ff[g] <= nxt_len;
				err_ff[g] <= nxt_err;
				hist_ff <= nxt_hist;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	property p_err_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		err_ff[6] == ERR_MAX && !g_ber[6].start_wr |=> err_ff[6] == ERR_MAX;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error count left its maximum"); // see R5

	property p_reg_ack;
		@(posedge clk_i) disable iff (!rst_n_i)
		state_ff == H_IDLE && host_req_i && !host_addr_i[SPACE_BIT] |=> host_ack_o;
	endproperty
	a_reg_ack: assert property (p_reg_ack) else $error("register access not acknowledged next cycle"); // see R6

	property p_mem_route;
		@(posedge clk_i) disable iff (!rst_n_i)
		state_ff == H_IDLE && host_req_i && host_addr_i[SPACE_BIT] |=> !host_ack_o ##0 state_ff == H_MEM;
	endproperty
	a_mem_route: assert property (p_mem_route) else $error("memory access not routed to memory"); // see R6

	property p_cml_write;
		@(posedge clk_i) disable iff (!rst_n_i)
		cml_wr |-> memsel == MEMSEL_CM_LOW && hwr_ff ##1 host_ack_o;
	endproperty
	a_cml_write: assert property (p_cml_write) else $error("connection low written under wrong select"); // see R7

	property p_tx_latency;
		@(posedge clk_i) disable iff (!rst_n_i)
		tx_req_i |-> ##3 tx_valid_o;
	endproperty
	a_tx_latency: assert property (p_tx_latency) else $error("output result not three cycles after request"); // see R9

	property p_tristate;
		@(posedge clk_i) disable iff (!rst_n_i)
		tx_s2_ff && s2_cml_ff[CML_MODE_BIT] && s2_cml_ff[2:1] == OSEL_TRISTATE |=> !tx_oe_o && tx_byte_o == 8'h00;
	endproperty
	a_tristate: assert property (p_tristate) else $error("tristate channel drove its output"); // see R14

	property p_message;
		@(posedge clk_i) disable iff (!rst_n_i)
		tx_s2_ff && s2_cml_ff[CML_MODE_BIT] && s2_cml_ff[2:1] == OSEL_MESSAGE && !s2_cml_ff[CML_CONV_BIT]
		|=> tx_oe_o && tx_byte_o == $past(s2_cml_ff[10:3]);
	endproperty
	a_message: assert property (p_message) else $error("message byte not sent"); // see R13

	property p_pass;
		@(posedge clk_i) disable iff (!rst_n_i)
		tx_s2_ff && !s2_cml_ff[CML_MODE_BIT] && s2_cmh_ff[2:1] == s2_cmh_ff[4:3] |=> tx_byte_o == $past(dm_q);
	endproperty
	a_pass: assert property (p_pass) else $error("equal laws altered the byte"); // see R17

	property p_ber_raw;
		@(posedge clk_i) disable iff (!rst_n_i)
		tx_ber_o |-> tx_oe_o && tx_byte_o == 8'h00 && !tx_var_delay_o;
	endproperty
	a_ber_raw: assert property (p_ber_raw) else $error("test channel output was translated"); // see R19

	property p_window;
		@(posedge clk_i) disable iff (!rst_n_i)
		rx_valid_i && rx_stream_i == 5'h05 && !g_ber[5].start_wr
		&& (rx_channel_i < start_ff[5] || {2'h0, rx_channel_i} >= {2'h0, start_ff[5]} + {1'b0, len_ff[5]})
		|=> err_ff[5] == $past(err_ff[5]);
	endproperty
	a_window: assert property (p_window) else $error("counted outside the test window"); // see R1

	c_switch: cover property (@(posedge clk_i) disable iff (!rst_n_i) tx_valid_o && tx_oe_o && !tx_ber_o);
	c_err_sat: cover property (@(posedge clk_i) disable iff (!rst_n_i) err_ff[6] == ERR_MAX);
	c_host_mem_rd: cover property (@(posedge clk_i) disable iff (!rst_n_i) state_ff == H_DATA ##1 host_ack_o);
endmodule

// [tcmbr_pkg.sv]
// Constants and types for the connection memory and bit-error receiver block
// Operation
// R1: Per stream, an 8-bit start field gives the first compared input channel.
// R2: Per stream, a 9-bit length field gives how many channels carry the pattern.
// R3: Software keeps length within 32, 64, 128 or 256 by stream rate.
// R4: Software programs a length of at least one channel.
// R5: Per stream 16-bit read-only error counter saturates at its maximum.
// R6: Top address bit high reaches memories, low reaches registers.
// R7: Two low control bits pick data memory, connection low or high.
// R8: Address bits 12..8 pick stream, bits 7..0 pick channel.
// R9: Mode bit zero in the low word means normal switching.
// R10: Bit 14 picks constant-delay or variable-delay source.
// R11: Software enables variable delay before choosing it on a channel.
// R12: Bits 13..9 give source stream, bits 8..1 source channel.
// R13: Mode bit one means per-channel control; bits 10..3 are message byte.
// R14: Bits 2..1 choose tristate, message, bit-error test or reserved.
// R15: Software writes the high word before setting the convert enable bit.
// R16: Differing input and output laws translate every byte of the connection.
// R17: Equal input and output laws pass bytes untouched.
// R18: Voice/data bit chooses voice laws or bit-inversion data laws.
// R19: Translation applies to switched and message channels only.
// R20: Software writes zero to reserved receiver register bits.
// R21: Each mismatching received bit in the window adds one to the count.
// R22: High word field positions are chosen by this implementation.
package tcmbr_pkg;
	localparam int unsigned STR_W = 5;
	localparam int unsigned CH_W = 8;
	localparam int unsigned HADDR_W = 14;
	localparam int unsigned HDATA_W = 16;
	localparam int unsigned MEM_AW = 13;
	localparam int unsigned SPACE_BIT = 13;
	// Register offsets in register space
	localparam logic [13:0] REG_CTRL_OFS = 14'h0000;
	localparam logic [13:0] REG_START_OFS = 14'h0300;
	localparam logic [13:0] REG_LEN_OFS = 14'h0320;
	localparam logic [13:0] REG_ERR_OFS = 14'h0360;
	// Control register fields
	localparam int unsigned CTRL_MEMSEL_LSB = 0;
	localparam int unsigned CTRL_VARIABLE_DELAY_ENABLE_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [1:0] MEMSEL_CM_LOW = 2'h0;
	localparam logic [1:0] MEMSEL_CM_HIGH = 2'h1;
	localparam logic [1:0] MEMSEL_DATA = 2'h2;
	// Connection word low fields
	localparam int unsigned CML_MODE_BIT = 0;
	localparam int unsigned CML_SRC_LSB = 1;
	localparam int unsigned CML_OSEL_LSB = 1;
	localparam int unsigned CML_MSG_LSB = 3;
	localparam int unsigned CML_VAR_BIT = 14;
	localparam int unsigned CML_CONV_BIT = 15;
	localparam logic [1:0] OSEL_TRISTATE = 2'h0;
	localparam logic [1:0] OSEL_MESSAGE = 2'h1;
	localparam logic [1:0] OSEL_BER = 2'h2;
	// Connection word high fields
	localparam int unsigned CMH_VD_BIT = 0;
	localparam int unsigned CMH_ICL_LSB = 1;
	localparam int unsigned CMH_OCL_LSB = 3;
	// Data-class inversion masks, indexed by law code
	localparam logic [31:0] DATA_MASKS = 32'hAAFF_5500;
	// Receiver reset values and limits
	localparam logic [7:0] START_RST = 8'h00;
	localparam logic [8:0] LEN_RST = 9'h000;
	localparam logic [15:0] ERR_RST = 16'h0000;
	localparam logic [15:0] ERR_MAX = 16'hFFFF;
	// Request to valid output, in clock cycles
	localparam int unsigned TX_LATENCY = 3;
	typedef enum logic [2:0] {
		H_IDLE = 3'b001,
		H_MEM = 3'b010,
		H_DATA = 3'b100
	} tcmbr_host_state_t;
endpackage

// [tcmbr_ram.sv]
// Single write, single read memory with registered read data
`timescale 1ns/1ps
module tcmbr_ram #(
	parameter int unsigned DW = 16,
	parameter int unsigned AW = 13
) (
	// Clock
	input wire logic clk_i,
	// Write port
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [DW-1:0] wr_data_i,
	// Read port
	input wire logic rd_en_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [DW-1:0] rd_data_o
);
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge clk_i)
	begin
		if (wr_en_i)
		begin
			mem[wr_addr_i] <= wr_data_i;
		end
		if (rd_en_i)
		begin
			rd_data_o <= mem[rd_addr_i];
		end
	end
endmodule

// [tcmbr_host_model.sv]
// Microprocessor model that drives the host port one word at a time
`timescale 1ns/1ps
module tcmbr_host_model (
	// Clock
	input wire logic clk_i,
	// Request side
	output logic host_req_o,
	output logic host_wr_o,
	output logic [tcmbr_pkg::HADDR_W-1:0] host_addr_o,
	output logic [tcmbr_pkg::HDATA_W-1:0] host_wdata_o,
	// Answer side
	input wire logic host_ack_i,
	input wire logic [tcmbr_pkg::HDATA_W-1:0] host_rdata_i
);
	import tcmbr_pkg::*;
	initial
	begin
		host_req_o = 1'b0;
		host_wr_o = 1'b0;
		host_addr_o = '0;
		host_wdata_o = '0;
	end
	////////////////////////////////////////////////////////////////
	// Qualifiers are inverted after the answer so a stale address never looks valid
	task automatic access(input logic wr, input logic [HADDR_W-1:0] a, input logic [HDATA_W-1:0] d,
		output logic [HDATA_W-1:0] r, output bit ok);
		ok = 1'b0;
		r = '0;
		@(posedge clk_i);
		host_req_o <= 1'b1;
		host_wr_o <= wr;
		host_addr_o <= a;
		host_wdata_o <= d;
		@(posedge clk_i);
		host_req_o <= 1'b0;
		for (int i = 0; i < 64 && !ok; i++)
		begin
			@(posedge clk_i);
			if (host_ack_i === 1'b1)
			begin
				ok = 1'b1;
				r = host_rdata_i;
				host_wr_o <= ~wr;
				host_addr_o <= ~a;
				host_wdata_o <= ~d;
			end
		end
	endtask
endmodule

// [tcmbr_top_test.sv]
// Self-checking testbench for the connection memory and bit-error receiver block
`timescale 1ns/1ps
module tcmbr_top_test;
	import tcmbr_pkg::*;
	logic clk_i;
	logic rst_n_i;
	logic host_req, host_wr, host_ack, rx_valid, tx_req, tx_valid, tx_oe, tx_ber, tx_var;
	logic [HADDR_W-1:0] host_addr;
	logic [HDATA_W-1:0] host_wdata, host_rdata;
	logic [STR_W-1:0] rx_stream, tx_stream;
	logic [CH_W-1:0] rx_channel, tx_channel;
	logic [7:0] rx_byte, tx_byte;
	int n_mismatch = 0;
	int cmp_count = 0;
	tcmbr_top #(.N_STREAMS(32)) tcmbr_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .host_req_i(host_req),
		.host_wr_i(host_wr), .host_addr_i(host_addr), .host_wdata_i(host_wdata), .host_ack_o(host_ack),
		.host_rdata_o(host_rdata), .rx_valid_i(rx_valid), .rx_stream_i(rx_stream), .rx_channel_i(rx_channel),
		.rx_byte_i(rx_byte), .tx_req_i(tx_req), .tx_stream_i(tx_stream), .tx_channel_i(tx_channel),
		.tx_valid_o(tx_valid), .tx_byte_o(tx_byte), .tx_oe_o(tx_oe), .tx_ber_o(tx_ber), .tx_var_delay_o(tx_var));
	tcmbr_host_model tcmbr_host_model_inst (.clk_i(clk_i), .host_req_o(host_req), .host_wr_o(host_wr),
		.host_addr_o(host_addr), .host_wdata_o(host_wdata), .host_ack_i(host_ack), .host_rdata_i(host_rdata));
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic access(input logic w, input logic [13:0] a, input logic [15:0] d, output logic [15:0] r);
		bit ok;
		tcmbr_host_model_inst.access(w, a, d, r, ok);
		if (!ok)
		begin
			$display("unexpected at %0t: host access never answered", $time);
			n_mismatch++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [13:0] a, input logic [15:0] d);
		logic [15:0] r;
		access(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [13:0] a, input logic [15:0] e);
		logic [15:0] r;
		access(1'b0, a, 16'h0000, r);
		check(r, e);
	endtask
	// High word is reached only through memory select 01, then select 00 is restored
	task automatic cmh(input logic [15:0] v);
		wr(14'h0000, 16'h0005);
		wr(14'h2203, v);
		wr(14'h0000, 16'h0004);
	endtask
	task automatic rx(input logic [4:0] s, input logic [7:0] c, input logic [7:0] b);
		@(posedge clk_i);
		rx_valid <= 1'b1;
		rx_stream <= s;
		rx_channel <= c;
		rx_byte <= b;
	endtask
	task automatic rx_end();
		@(posedge clk_i);
		rx_valid <= 1'b0;
		rx_byte <= ~rx_byte;
	endtask
	task automatic tx(input logic [4:0] s, input logic [7:0] c, input logic [7:0] b, input logic [2:0] f);
		@(posedge clk_i);
		tx_req <= 1'b1;
		tx_stream <= s;
		tx_channel <= c;
		@(posedge clk_i);
		tx_req <= 1'b0;
		tx_stream <= ~s;
		tx_channel <= ~c;
		#1;
		for (int i = 0; i < 8 && tx_valid !== 1'b1; i++)
		begin
			@(posedge clk_i);
			#1;
		end
		check(16'(tx_valid), 16'h0001);
		check(16'(tx_byte), 16'(b));
		check(16'({tx_oe, tx_ber, tx_var}), 16'(f));
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		logic [7:0] eb [4];
		logic [2:0] ef [4];
		logic [13:0] ra [5];
		eb = '{8'h00, 8'hC3, 8'h00, 8'h00};
		ef = '{3'b000, 3'b100, 3'b110, 3'b000};
		ra = '{14'h0000, 14'h0300, 14'h0320, 14'h0360, 14'h0100};
		rst_n_i = 1'b0;
		rx_valid = 1'b0;
		rx_stream = '0;
		rx_channel = '0;
		rx_byte = '0;
		tx_req = 1'b0;
		tx_stream = '0;
		tx_channel = '0;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		foreach (ra[i]) rd(ra[i], 16'h0000);
		wr(14'h0303, 16'h00FF);
		wr(14'h0323, 16'h0100);
		rd(14'h0303, 16'h00FF);
		rd(14'h0323, 16'h0100);
		wr(14'h0363, 16'h1234);
		rd(14'h0363, 16'h0000);
		$display("test registers done");
		// Boundary source stream 31 channel 255, plus a mid-range source
		rx(5'h1F, 8'hFF, 8'hA5);
		rx(5'h04, 8'h07, 8'h5A);
		rx_end();
		wr(14'h2000, 16'h3FFE);
		wr(14'h2203, 16'h480E);
		rd(14'h2000, 16'h3FFE);
		rd(14'h0303, 16'h00FF);
		tx(5'h00, 8'h00, 8'hA5, 3'b100);
		tx(5'h02, 8'h03, 8'h5A, 3'b100);
		wr(14'h0000, 16'h0004);
		tx(5'h02, 8'h03, 8'h5A, 3'b101);
		wr(14'h0000, 16'h0006);
		rd(14'h2407, 16'h005A);
		$display("test switching done");
		cmh(16'h0009);
		wr(14'h0000, 16'h0005);
		rd(14'h2203, 16'h0009);
		wr(14'h0000, 16'h0004);
		rd(14'h2203, 16'h480E);
		wr(14'h2203, 16'h880E);
		tx(5'h02, 8'h03, 8'h0F, 3'b100);
		cmh(16'h000B);
		tx(5'h02, 8'h03, 8'h5A, 3'b100);
		cmh(16'h0011);
		for (int i = 0; i < 4; i++)
		begin
			wr(14'h2203, 16'h81E1 | (16'(i) << 1));
			tx(5'h02, 8'h03, eb[i], ef[i]);
		end
		wr(14'h2203, 16'h01E3);
		tx(5'h02, 8'h03, 8'h3C, 3'b100);
		// Voice laws: A-law 0xA5 to mu-law, then the same byte read as mu-law to A-law
		cmh(16'h0008);
		wr(14'h2203, 16'hBFFE);
		tx(5'h02, 8'h03, 8'h9E, 3'b100);
		wr(14'h2203, 16'h3FFE);
		cmh(16'h0002);
		wr(14'h2203, 16'hBFFE);
		tx(5'h02, 8'h03, 8'h8C, 3'b100);
		$display("test channel modes done");
		wr(14'h0325, 16'h0008);
		for (int i = 0; i < 8; i++) rx(5'h05, 8'(i), 8'h00);
		rx_end();
		wr(14'h0305, 16'h0000);
		rd(14'h0365, 16'h0000);
		// One flipped bit also spoils the two predictions 14 and 15 bits later
		rx(5'h05, 8'h00, 8'h00);
		rx(5'h05, 8'h01, 8'h80);
		rx(5'h05, 8'h02, 8'h00);
		rx(5'h05, 8'h03, 8'h00);
		rx_end();
		rd(14'h0365, 16'h0003);
		rx(5'h05, 8'h08, 8'hFF);
		rx_end();
		rd(14'h0365, 16'h0003);
		wr(14'h0326, 16'h0100);
		for (int i = 0; i < 8300; i++) rx(5'h06, 8'(i), 8'hFF);
		rx_end();
		rd(14'h0366, 16'hFFFF);
		wr(14'h0366, 16'h0000);
		rd(14'h0366, 16'hFFFF);
		wr(14'h0306, 16'h0000);
		rd(14'h0366, 16'h0000);
		$display("test receiver done");
		end_of_test();
	end
endmodule
